// ==== core/alsctl_core.sv ====
// Purpose: i2c slave, conversion timing and threshold alarm of a light sensor
// Assumes: scl and sda come from outside and are synchronised here
// Notes: photodiode levels are given as digital sample inputs per conversion tick
//
// Summary of operation
// - answer only our fixed seven-bit address
// - command and control hold until rewritten, except alert_status, which the alarm sets
// - source bits pick wideband, infrared or difference
// - difference: wideband first, infrared second, subtract
// - length bits set 2^16/12/8/4 cycles
// - timing bit picks internal or host timing
// - internal timing counts oscillator cycles to length
// - host timing: period between restart commands
// - address bit 7 write ends a host-timed period; no effect under internal timing
// - address bit 6 write clears alarm
// - converter_on low holds converter in reset
// - sleep_request high powers device down
// - alert_status reads one once alarm fired
// - range bits set full-scale lux range
// - persistence needs 1, 4, 8, 16 hits
// - threshold registers hold high bytes, reset values
// - out of window: above upper or below lower
// - alarm pulls open-drain pin low
// - registers 4 and 5 give result
// - registers 6 and 7 give cycle count
// - thresholds use zero low byte
// - writing zero to alert_status clears it
// - result updated every conversion end, every second one in difference mode
// - cycle counter captured at conversion end
`timescale 1ns/1ps
module alsctl_core
  import alsctl_pkg::*;
#(
  parameter int SAMPLE_WIDTH = 16
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic alarmOutN,
  output logic alarmOutOe,
  input wire logic [SAMPLE_WIDTH-1:0] widebandPhotodiode,
  input wire logic [SAMPLE_WIDTH-1:0] infraredPhotodiode,
  output logic [1:0] rangeSelect,
  output logic powerDown
);

  typedef struct packed {
    logic [1:0] sclSync;
    logic [1:0] sdaSync;
    logic sclLast;
    logic sdaLast;
    alsctl_i2c_state_t i2cState;
    logic [7:0] shiftReg;
    logic [2:0] bitCount;
    logic gotBit;
    logic [7:0] regPtr;
    logic readMode;
    logic sdaOut;
    logic sdaOe;
    alsctl_regs_t regs;
    logic [8:0] oscDiv;
    logic [16:0] convCounter;
    logic [15:0] cycleCounter;
    logic diffSecond;
    logic [15:0] firstResult;
    logic [4:0] hitCount;
    logic alarmOutN;
    logic alarmOutOe;
    logic [1:0] rangeSelect;
    logic powerDown;
  } alsctl_state_t;

  alsctl_state_t cur;
  alsctl_state_t next_cur;

  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic oscTick;
  logic convEnd;
  logic restartCmd;
  logic clearCmd;
  logic [16:0] lengthCycles;
  logic [15:0] sample;
  logic [15:0] finalResult;
  logic [4:0] persistNeed;
  logic outOfWindow;
  logic [7:0] readByte;
  logic byteDone;

  always_comb begin
    next_cur = cur;
    sclRise = cur.sclSync[1] & ~cur.sclLast;
    sclFall = ~cur.sclSync[1] & cur.sclLast;
    startSeen = cur.sclSync[1] & cur.sclLast & cur.sdaLast & ~cur.sdaSync[1];
    stopSeen = cur.sclSync[1] & cur.sclLast & ~cur.sdaLast & cur.sdaSync[1];
    restartCmd = 1'b0;
    clearCmd = 1'b0;
    // a byte is complete only after eight rises since the last boundary;
    // the scl fall that closes a start condition must not count as one
    byteDone = sclFall && cur.bitCount == 3'h0 && cur.gotBit;
    next_cur.sclSync = {cur.sclSync[0], sclIn};
    next_cur.sdaSync = {cur.sdaSync[0], sdaIn};
    next_cur.sclLast = cur.sclSync[1];
    next_cur.sdaLast = cur.sdaSync[1];

    case (cur.regPtr[2:0])
      REG_ADC_COMMAND: readByte = cur.regs.adcCommand;
      REG_SENSOR_CONTROL: readByte = cur.regs.sensorControl;
      REG_UPPER_ALARM_LEVEL: readByte = cur.regs.upperAlarmLevel;
      REG_LOWER_ALARM_LEVEL: readByte = cur.regs.lowerAlarmLevel;
      REG_LIGHT_RESULT_LOW: readByte = cur.regs.lightResult[7:0];
      REG_LIGHT_RESULT_HIGH: readByte = cur.regs.lightResult[15:8];
      REG_CYCLE_COUNT_LOW: readByte = cur.regs.cycleCount[7:0];
      REG_CYCLE_COUNT_HIGH: readByte = cur.regs.cycleCount[15:8];
      default: readByte = 8'h00;
    endcase

    // i2c slave; start and stop override every state
    if (startSeen) begin
      next_cur.i2cState = I2C_ADDR;
      next_cur.bitCount = 3'h0;
      next_cur.gotBit = 1'b0;
      next_cur.shiftReg = 8'h00;
      next_cur.sdaOe = 1'b0;
    end else if (stopSeen) begin
      next_cur.i2cState = I2C_IDLE;
      next_cur.gotBit = 1'b0;
      next_cur.sdaOe = 1'b0;
    end else begin
      case (cur.i2cState)
        I2C_ADDR, I2C_REG, I2C_WDATA: begin
          if (sclRise) begin
            next_cur.shiftReg = {cur.shiftReg[6:0], cur.sdaSync[1]};
            next_cur.bitCount = cur.bitCount + 3'h1;
            next_cur.gotBit = 1'b1;
          end
          if (byteDone) begin
            next_cur.gotBit = 1'b0;
          end
          if (byteDone && cur.i2cState == I2C_ADDR) begin
            if (cur.shiftReg[7:1] == SLAVE_ADDR) begin
              next_cur.readMode = cur.shiftReg[0];
              next_cur.i2cState = I2C_ADDR_ACK;
              next_cur.sdaOe = 1'b1;
              next_cur.sdaOut = 1'b0;
            end else begin
              next_cur.i2cState = I2C_IGNORE;
            end
          end else if (byteDone && cur.i2cState == I2C_REG) begin
            next_cur.regPtr = cur.shiftReg;
            next_cur.i2cState = I2C_REG_ACK;
            next_cur.sdaOe = 1'b1;
            next_cur.sdaOut = 1'b0;
            // command bits ride on the register address byte
            restartCmd = cur.shiftReg[ADDR_RESTART_BIT];
            clearCmd = cur.shiftReg[ADDR_ALARM_CLEAR_BIT];
          end else if (byteDone && cur.i2cState == I2C_WDATA) begin
            next_cur.i2cState = I2C_WACK;
            next_cur.sdaOe = 1'b1;
            next_cur.sdaOut = 1'b0;
            case (cur.regPtr[2:0])
              REG_ADC_COMMAND: next_cur.regs.adcCommand = cur.shiftReg;
              REG_SENSOR_CONTROL: begin
                // only the alert bit can be cleared, never set, by software
                next_cur.regs.sensorControl = (cur.shiftReg & CTL_WRITE_MASK) |
                  (cur.regs.sensorControl & ~CTL_WRITE_MASK);
                if (!cur.shiftReg[CTL_ALERT_STATUS]) begin
                  clearCmd = 1'b1;
                end
              end
              REG_UPPER_ALARM_LEVEL: next_cur.regs.upperAlarmLevel = cur.shiftReg;
              REG_LOWER_ALARM_LEVEL: next_cur.regs.lowerAlarmLevel = cur.shiftReg;
              default: ; // data registers are read only
            endcase
          end
        end
        I2C_ADDR_ACK: begin
          if (sclFall) begin
            next_cur.bitCount = 3'h0;
            next_cur.shiftReg = 8'h00;
            if (cur.readMode) begin
              next_cur.i2cState = I2C_RDATA;
              next_cur.shiftReg = {readByte[6:0], 1'b0};
              next_cur.sdaOut = readByte[7];
              next_cur.sdaOe = ~readByte[7];
              next_cur.bitCount = 3'h1;
            end else begin
              next_cur.i2cState = I2C_REG;
              next_cur.sdaOe = 1'b0;
            end
          end
        end
        I2C_REG_ACK, I2C_WACK: begin
          if (sclFall) begin
            next_cur.i2cState = I2C_WDATA;
            next_cur.bitCount = 3'h0;
            next_cur.sdaOe = 1'b0;
            if (cur.i2cState == I2C_WACK) begin
              next_cur.regPtr = {cur.regPtr[7:3], cur.regPtr[2:0] + 3'h1};
            end
          end
        end
        I2C_RDATA: begin
          if (sclFall) begin
            if (cur.bitCount == 3'h0) begin
              next_cur.i2cState = I2C_RACK;
              next_cur.sdaOe = 1'b0;
            end else begin
              next_cur.sdaOut = cur.shiftReg[7];
              next_cur.sdaOe = ~cur.shiftReg[7];
              next_cur.shiftReg = {cur.shiftReg[6:0], 1'b0};
              next_cur.bitCount = cur.bitCount + 3'h1;
            end
          end
        end
        I2C_RACK: begin
          if (sclRise) begin
            next_cur.regPtr = {cur.regPtr[7:3], cur.regPtr[2:0] + 3'h1};
            next_cur.i2cState = cur.sdaSync[1] ? I2C_IGNORE : I2C_RACK;
          end else if (sclFall) begin
            next_cur.i2cState = I2C_RDATA;
            next_cur.shiftReg = {readByte[6:0], 1'b0};
            next_cur.sdaOut = readByte[7];
            next_cur.sdaOe = ~readByte[7];
            next_cur.bitCount = 3'h1;
          end
        end
        I2C_IGNORE, I2C_IDLE: next_cur.sdaOe = 1'b0;
        default: next_cur.i2cState = I2C_IDLE;
      endcase
    end
    // open-drain: drive only lows
    if (next_cur.sdaOe) begin
      next_cur.sdaOut = 1'b0;
    end

    // conversion timing on the dual-speed oscillator
    case (cur.regs.adcCommand[1:0])
      2'h0: lengthCycles = 17'h10000;
      2'h1: lengthCycles = 17'h01000;
      2'h2: lengthCycles = 17'h00100;
      default: lengthCycles = 17'h00010;
    endcase
    oscTick = (cur.oscDiv == 9'h000);
    if (!oscTick) begin
      next_cur.oscDiv = cur.oscDiv - 9'h001;
    end else if (cur.regs.sensorControl[3]) begin
      // upper two ranges run the oscillator at double speed
      next_cur.oscDiv = OSC_FAST_DIV - 9'h001;
    end else begin
      next_cur.oscDiv = OSC_SLOW_DIV - 9'h001;
    end
    if (cur.regs.adcCommand[CMD_TIMING_SOURCE]) begin
      convEnd = restartCmd;
    end else begin
      convEnd = oscTick && (cur.convCounter + 17'h1 >= lengthCycles);
    end
    case (cur.regs.adcCommand[3:2])
      IR_ONLY: sample = 16'(infraredPhotodiode);
      default: sample = 16'(widebandPhotodiode);
    endcase
    if (cur.regs.adcCommand[3:2] == DIFF_SELECT && cur.diffSecond) begin
      finalResult = 16'(cur.firstResult - 16'(infraredPhotodiode));
    end else begin
      finalResult = sample;
    end
    case (cur.regs.sensorControl[1:0])
      2'h0: persistNeed = 5'd1;
      2'h1: persistNeed = 5'd4;
      2'h2: persistNeed = 5'd8;
      default: persistNeed = 5'd16;
    endcase
    // difference result is signed; compare as stored bits
    outOfWindow = (finalResult > {cur.regs.upperAlarmLevel, 8'h00}) ||
                  (finalResult < {cur.regs.lowerAlarmLevel, 8'h00});

    if (!cur.regs.adcCommand[CMD_CONVERTER_ON] || cur.regs.adcCommand[CMD_SLEEP_REQUEST] ||
        cur.regs.adcCommand[3:2] == 2'h3) begin
      next_cur.convCounter = 17'h0;
      next_cur.cycleCounter = 16'h0;
      next_cur.diffSecond = 1'b0;
      // a restarted core counts persistence afresh
      next_cur.hitCount = 5'd0;
    end else if (convEnd) begin
      next_cur.convCounter = 17'h0;
      next_cur.cycleCounter = 16'h0;
      // the tick that ends the period is counted too
      next_cur.regs.cycleCount = cur.cycleCounter + {15'h0000, oscTick};
      if (cur.regs.adcCommand[3:2] == DIFF_SELECT && !cur.diffSecond) begin
        next_cur.firstResult = 16'(widebandPhotodiode);
        next_cur.diffSecond = 1'b1;
      end else begin
        next_cur.diffSecond = 1'b0;
        next_cur.regs.lightResult = finalResult;
        if (!outOfWindow) begin
          next_cur.hitCount = 5'd0;
        end else if (cur.hitCount + 5'd1 >= persistNeed) begin
          next_cur.hitCount = 5'd0;
          next_cur.regs.sensorControl[CTL_ALERT_STATUS] = 1'b1;
        end else begin
          next_cur.hitCount = cur.hitCount + 5'd1;
        end
      end
    end else if (oscTick) begin
      next_cur.convCounter = cur.convCounter + 17'h1;
      next_cur.cycleCounter = cur.cycleCounter + 16'h1;
    end

    // set wins over clear only when the flag was clear: a firing in this cycle then keeps it
    if (clearCmd && !(convEnd && next_cur.regs.sensorControl[CTL_ALERT_STATUS] &&
        !cur.regs.sensorControl[CTL_ALERT_STATUS])) begin
      next_cur.regs.sensorControl[CTL_ALERT_STATUS] = 1'b0;
    end
    next_cur.alarmOutN = ~next_cur.regs.sensorControl[CTL_ALERT_STATUS];
    next_cur.alarmOutOe = next_cur.regs.sensorControl[CTL_ALERT_STATUS];
    next_cur.rangeSelect = cur.regs.sensorControl[3:2];
    next_cur.powerDown = cur.regs.adcCommand[CMD_SLEEP_REQUEST];
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      // idle bus levels, so no false edge follows reset
      cur.sclSync <= 2'h3;
      cur.sdaSync <= 2'h3;
      cur.sclLast <= 1'b1;
      cur.sdaLast <= 1'b1;
      cur.i2cState <= I2C_IDLE;
      cur.shiftReg <= 8'h00;
      cur.bitCount <= 3'h0;
      cur.gotBit <= 1'b0;
      cur.regPtr <= 8'h00;
      cur.readMode <= 1'b0;
      cur.sdaOut <= 1'b0;
      cur.sdaOe <= 1'b0;
      cur.regs.adcCommand <= RESET_ADC_COMMAND;
      cur.regs.sensorControl <= RESET_SENSOR_CONTROL;
      cur.regs.upperAlarmLevel <= RESET_UPPER_ALARM_LEVEL;
      cur.regs.lowerAlarmLevel <= RESET_LOWER_ALARM_LEVEL;
      cur.regs.lightResult <= 16'h0000;
      cur.regs.cycleCount <= 16'h0000;
      cur.oscDiv <= 9'h000;
      cur.convCounter <= 17'h00000;
      cur.cycleCounter <= 16'h0000;
      cur.diffSecond <= 1'b0;
      cur.firstResult <= 16'h0000;
      cur.hitCount <= 5'h00;
      cur.alarmOutN <= 1'b1;
      cur.alarmOutOe <= 1'b0;
      cur.rangeSelect <= 2'h0;
      cur.powerDown <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  assign sdaOut = cur.sdaOut;
  assign sdaOe = cur.sdaOe;
  assign alarmOutN = cur.alarmOutN;
  assign alarmOutOe = cur.alarmOutOe;
  assign rangeSelect = cur.rangeSelect;
  assign powerDown = cur.powerDown;

endmodule // alsctl_core

// ==== core/alsctl_pkg.sv ====
// Purpose: shared constants and types for the light sensor control core
// Assumes: 100 MHz system clock, i2c slave with 8-bit registers
// Notes: register indices are the i2c register addresses
package alsctl_pkg;
  localparam logic [6:0] SLAVE_ADDR = 7'h44;
  localparam logic [2:0] REG_ADC_COMMAND = 3'h0;
  localparam logic [2:0] REG_SENSOR_CONTROL = 3'h1;
  localparam logic [2:0] REG_UPPER_ALARM_LEVEL = 3'h2;
  localparam logic [2:0] REG_LOWER_ALARM_LEVEL = 3'h3;
  localparam logic [2:0] REG_LIGHT_RESULT_LOW = 3'h4;
  localparam logic [2:0] REG_LIGHT_RESULT_HIGH = 3'h5;
  localparam logic [2:0] REG_CYCLE_COUNT_LOW = 3'h6;
  localparam logic [2:0] REG_CYCLE_COUNT_HIGH = 3'h7;
  localparam int ADDR_RESTART_BIT = 7;
  localparam int ADDR_ALARM_CLEAR_BIT = 6;
  localparam int CMD_CONVERTER_ON = 7;
  localparam int CMD_SLEEP_REQUEST = 6;
  localparam int CMD_TIMING_SOURCE = 5;
  localparam int CTL_ALERT_STATUS = 5;
  localparam logic [7:0] RESET_ADC_COMMAND = 8'h00;
  localparam logic [7:0] RESET_SENSOR_CONTROL = 8'h00;
  localparam logic [7:0] RESET_UPPER_ALARM_LEVEL = 8'hFF;
  localparam logic [7:0] RESET_LOWER_ALARM_LEVEL = 8'h00;
  localparam logic [7:0] CTL_WRITE_MASK = 8'h0F;
  localparam logic [1:0] WIDE_ONLY = 2'h0;
  localparam logic [1:0] IR_ONLY = 2'h1;
  localparam logic [1:0] DIFF_SELECT = 2'h2;
  // oscillator: 327 kHz slow, 655 kHz fast, as ticks of clk_sys
  localparam int SYS_CLK_KHZ = 100000;
  localparam int OSC_SLOW_KHZ = 327;
  localparam int OSC_FAST_KHZ = 655;
  localparam logic [8:0] OSC_SLOW_DIV = 9'(SYS_CLK_KHZ / OSC_SLOW_KHZ);
  localparam logic [8:0] OSC_FAST_DIV = 9'(SYS_CLK_KHZ / OSC_FAST_KHZ);

  typedef enum {I2C_IDLE, I2C_ADDR, I2C_ADDR_ACK, I2C_REG, I2C_REG_ACK,
                I2C_WDATA, I2C_WACK, I2C_RDATA, I2C_RACK, I2C_IGNORE} alsctl_i2c_state_t;

  typedef struct packed {
    logic [7:0] adcCommand;
    logic [7:0] sensorControl;
    logic [7:0] upperAlarmLevel;
    logic [7:0] lowerAlarmLevel;
    logic [15:0] lightResult;
    logic [15:0] cycleCount;
  } alsctl_regs_t;
endpackage

// ==== tb/alsctl_core_assertions.sv ====
// Purpose: port checks of the light sensor core
// Assumes: scl half periods long against the input sync
// Notes: the core moves sda, range and power and drops the alarm only while scl is low; a firing alarm can rise at any time
`timescale 1ns/1ps
module alsctl_core_assertions (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic sclIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic alarmOutN,
  input wire logic alarmOutOe,
  input wire logic [1:0] rangeSelect,
  input wire logic powerDown
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  a_reset_idle: assert property (disable iff (1'b0) reset |-> !sdaOe && alarmOutN
    && !alarmOutOe && rangeSelect == 2'h0 && !powerDown) else $error("busy in reset");
  a_sda_pull_only: assert property (sdaOe |-> !sdaOut)
    else $error("sda driven high");
  a_drive_in_low: assert property ($rose(sdaOe) |-> !sclIn ##0 sdaOe [*4])
    else $error("sda drive not held in scl low");
  a_sda_still_high: assert property (sclIn && $past(sclIn) |-> $stable(sdaOe))
    else $error("sda moved while scl high");
  a_alarm_pin: assert property (alarmOutOe == !alarmOutN)
    else $error("alarm enable and level disagree");
  a_alarm_clear_bus: assert property ($fell(alarmOutOe) |-> !sclIn)
    else $error("alarm dropped outside a bus write");
  a_range_on_write: assert property ($changed(rangeSelect) |-> !sclIn)
    else $error("range moved outside a bus write");
  a_power_on_write: assert property ($changed(powerDown) |-> !sclIn)
    else $error("power state moved outside a bus write");
endmodule // alsctl_core_assertions
bind alsctl_core alsctl_core_assertions alsctl_core_assertions_i (
  .clk_sys(clk_sys), .reset(reset), .sclIn(sclIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .alarmOutN(alarmOutN), .alarmOutOe(alarmOutOe), .rangeSelect(rangeSelect),
  .powerDown(powerDown)
);

// ==== tb/alsctl_i2c_master.sv ====
// Purpose: i2c bus master model facing the sensor core
// Assumes: sda has a pull-up, the model alone drives scl
// Notes: scl stands high between frames; half periods of 62.5 ns
`timescale 1ns/1ps
module alsctl_i2c_master
  import alsctl_pkg::*;
#(
  parameter realtime QTR = 31.25
) (
  input wire logic sdaLine,
  output logic scl,
  output logic sdaLow
);
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  // serves as repeated start too: sda falls while scl is high
  task automatic start();
    #QTR sdaLow = 1'b0;
    #QTR scl = 1'b1;
    #QTR sdaLow = 1'b1;
    #QTR scl = 1'b0;
  endtask
  task automatic stop();
    #QTR sdaLow = 1'b1;
    #QTR scl = 1'b1;
    #QTR sdaLow = 1'b0;
    #QTR;
  endtask
  // eight bits out, then the ninth; a one releases sda so the slave may pull
  task automatic xfer(input logic [7:0] d, input logic lastBit, output logic [7:0] r,
                      output logic ackSeen);
    logic [8:0] o;
    logic [8:0] s;
    o = {d, lastBit};
    for (int i = 8; i >= 0; i--) begin
      #QTR sdaLow = !o[i];
      #QTR scl = 1'b1;
      #QTR s[i] = sdaLine;
      #QTR scl = 1'b0;
    end
    r = s[8:1];
    ackSeen = !s[0];
  endtask
  // n of zero writes d; else reads n registers from ra on
  task automatic frame(input logic [7:0] ra, input logic [7:0] d, input int n,
                       output logic [7:0] q [8], output logic ok);
    logic [7:0] r;
    logic a0, a1, a2;
    start();
    xfer({SLAVE_ADDR, 1'b0}, 1'b1, r, a0);
    xfer(ra, 1'b1, r, a1);
    if (n == 0) begin
      xfer(d, 1'b1, r, a2);
    end else begin
      start();
      xfer({SLAVE_ADDR, 1'b1}, 1'b1, r, a2);
      for (int i = 0; i < n; i++) begin
        xfer(8'hFF, i == n - 1, q[i], r[0]);
      end
    end
    stop();
    ok = a0 && a1 && a2;
  endtask
endmodule // alsctl_i2c_master

// ==== tb/tb_alsctl_core.sv ====
// Purpose: bench for the light sensor core
// Assumes: the master model owns scl and pulls sda low
// Notes: photodiode inputs stand in for the analog side
`timescale 1ns/1ps
module tb_alsctl_core;
  import alsctl_pkg::*;
  // three fast-oscillator conversions of 16 ticks plus margin, in ns
  localparam int CONV_NS = 500 * OSC_FAST_DIV + 6000;
  logic clk_sys = 1'b0;
  logic reset = 1'b0;
  logic sclIn, sdaLow, sdaOut, sdaOe, alarmOutN, alarmOutOe, powerDown, ok;
  logic [1:0] rangeSelect;
  logic [15:0] wide = 16'h1234;
  logic [15:0] infra = 16'h0456;
  logic [15:0] expVal;
  logic [7:0] q [8];
  logic [7:0] rowReg [4] = '{8'h00, 8'h01, 8'h02, 8'h05};
  logic [7:0] rowDat [4] = '{8'h6B, 8'h0E, 8'h7F, 8'h55};
  logic [7:0] rowExp [4] = '{8'h6B, 8'h0E, 8'h7F, 8'h00};
  logic [7:0] convCmd [3] = '{8'h83, 8'h87, 8'h8B};
  wire sdaLine = !(sdaLow || sdaOe);
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #5 clk_sys = ~clk_sys;
  alsctl_core alsctl_core_i (
    .clk_sys(clk_sys), .reset(reset), .sclIn(sclIn), .sdaIn(sdaLine),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .alarmOutN(alarmOutN), .alarmOutOe(alarmOutOe),
    .widebandPhotodiode(wide), .infraredPhotodiode(infra),
    .rangeSelect(rangeSelect), .powerDown(powerDown)
  );
  alsctl_i2c_master alsctl_i2c_master_i (
    .sdaLine(sdaLine), .scl(sclIn), .sdaLow(sdaLow)
  );
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic end_sim();
    $display("compared %0d, mismatched %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 90000) begin
      err_total++;
      end_sim();
    end
  end
  initial begin
    #1 reset = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 reset = 1'b0;
    // keep bus moves off the clock edge, after the sync has settled
    repeat (3) @(posedge clk_sys);
    #1;
    alsctl_i2c_master_i.frame(8'h00, 8'h00, 8, q, ok);
    for (int i = 0; i < 8; i++) begin
      chk("reset value", (i == 2) ? 8'hFF : 8'h00, q[i]);
    end
    alsctl_i2c_master_i.start();
    alsctl_i2c_master_i.xfer({SLAVE_ADDR ^ 7'h01, 1'b0}, 1'b1, q[0], ok);
    alsctl_i2c_master_i.stop();
    chk("foreign address ack", 8'h00, {7'h00, ok});
    for (int k = 0; k < 4; k++) begin
      alsctl_i2c_master_i.frame(rowReg[k], rowDat[k], 0, q, ok);
      chk("write ack", 8'h01, {7'h00, ok});
      alsctl_i2c_master_i.frame(rowReg[k], 8'h00, 1, q, ok);
      chk("readback", rowExp[k], q[0]);
    end
    chk("power down", 8'h01, {7'h00, powerDown});
    chk("range", 8'h03, {6'h00, rangeSelect});
    for (int k = 0; k < 3; k++) begin
      alsctl_i2c_master_i.frame(8'h00, convCmd[k], 0, q, ok);
      #(CONV_NS);
      expVal = (k == 0) ? wide : (k == 1) ? infra : wide - infra;
      alsctl_i2c_master_i.frame(8'h04, 8'h00, 4, q, ok);
      chk("result low", expVal[7:0], q[0]);
      chk("result high", expVal[15:8], q[1]);
      chk("cycle count low", 8'h10, q[2]);
      chk("cycle count high", 8'h00, q[3]);
    end
    alsctl_i2c_master_i.frame(8'h02, 8'h0C, 0, q, ok);
    alsctl_i2c_master_i.frame(8'h01, 8'h08, 0, q, ok);
    #(CONV_NS);
    chk("alarm pin", 8'h00, {7'h00, alarmOutN});
    alsctl_i2c_master_i.frame(8'h01, 8'h00, 1, q, ok);
    chk("alert status", 8'h28, q[0]);
    // stop conversions first so no new result can race the clear
    alsctl_i2c_master_i.frame(8'h00, 8'h0B, 0, q, ok);
    chk("alarm held", 8'h01, {7'h00, alarmOutOe});
    alsctl_i2c_master_i.frame(8'h40, 8'h0B, 0, q, ok);
    chk("alarm cleared", 8'h01, {7'h00, alarmOutN});
    #(CONV_NS);
    chk("alarm stays off", 8'h01, {7'h00, alarmOutN});
    // host timing: only the restart command ends a period
    alsctl_i2c_master_i.frame(8'h00, 8'hA3, 0, q, ok);
    alsctl_i2c_master_i.frame(8'h80, 8'hA3, 0, q, ok);
    alsctl_i2c_master_i.frame(8'h04, 8'h00, 2, q, ok);
    chk("host result low", wide[7:0], q[0]);
    chk("host result high", wide[15:8], q[1]);
    chk("host alarm", 8'h00, {7'h00, alarmOutN});
    alsctl_i2c_master_i.frame(8'h01, 8'h08, 0, q, ok);
    chk("alert written clear", 8'h01, {7'h00, alarmOutN});
    @(posedge clk_sys);
    #1 reset = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 reset = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    alsctl_i2c_master_i.frame(8'h00, 8'h00, 4, q, ok);
    for (int i = 0; i < 4; i++) begin
      chk("mid-run reset value", (i == 2) ? 8'hFF : 8'h00, q[i]);
    end
    chk("reset alarm", 8'h01, {7'h00, alarmOutN});
    end_sim();
  end
endmodule // tb_alsctl_core
